// *** src/ssx_core.sv ***
// Serial transmit/receive core with an APB register slave
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "ssx_defs.svh"
// What this block does
// - Shift register loads from buffer or sync registers
// - Output shows shift low bit, loop slave retransmits
// - Bit counter loaded from source's own length
// - Serial transmit parity, appended when enabled except in mode 1
// - Mode 1 counts consecutive transmitted ones
// - One-cycle shift strobe per transmit clock fall
// - Divide-by-32: start second fall, then every 32nd
// - Request pin follows auto state or override bit
// - Reset or clear-transmit returns transmitter idle
// - Idle until enabled, finish last character
// - Receive sample every rise or every 32nd
// - Length copied to bit count at transfer
// - Receive parity checked except in mode 1
// - Transfer sets loaded flag, overrun if set
// - Comparator against first sync detects sync
// - Clear-receive resets mask, shifter, parity, flags
// - Init shifter marker zero signals completion
// - Low status bits switch on load flags
// - Interrupt pin low when enabled source active
// - Flag-clear write drops loaded and overrun flags
module ssx_core
	import ssx_pkg::*;
(
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic TX_CLK_N,
	input wire logic RX_CLK,
	input wire logic CTS_N,
	input wire logic DSR_N,
	input wire logic SERIAL_IN,
	output logic SERIAL_OUT,
	output logic RTS_N,
	output logic INT_N
);
	// Character length from a 3-bit code: 2 to 9 bits
	function automatic logic [3:0] ssx_len(input logic [2:0] code);
		return {1'b0, code} + 4'h2;
	endfunction : ssx_len
	// One serial step of the check register
	function automatic logic [15:0] ssx_crc(input logic [15:0] c, input logic b);
		return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `SSX_CRC_POLY : 16'h0000);
	endfunction : ssx_crc
	// Receive shifter preset: marker zero at bit len-1, ones below
	function automatic logic [9:0] ssx_rx_init(input logic [3:0] len);
		logic [9:0] v;
		v = 10'h3FF;
		v[len - 4'h1] = 1'b0;
		return v;
	endfunction : ssx_rx_init

	// Pin synchronisers; first stage is read only by the second
	logic [4:0] meta_q; // First stage
	logic [4:0] sync_q; // Second stage, safe to use
	logic [1:0] edge_q; // Previous line clock levels
	always_ff @(posedge MCLK) begin
		meta_q <= {SERIAL_IN, DSR_N, CTS_N, RX_CLK, TX_CLK_N};
		sync_q <= meta_q;
		edge_q <= sync_q[1:0];
	end
	wire tx_clk_s = sync_q[0];
	wire rx_clk_s = sync_q[1];
	wire cts_act = ~sync_q[2]; // Clear-to-send, active high inside
	wire dsr_act = ~sync_q[3];
	wire serial_in = sync_q[4];
	wire tx_fall = edge_q[0] & ~tx_clk_s;
	wire rx_rise = ~edge_q[1] & rx_clk_s;

	// Software-visible state
	logic [31:0] ctrl_q; // Control register
	logic [8:0] first_sync_char;
	logic [8:0] second_sync_char;
	logic [8:0] tx_data_buffer;
	logic [2:0] tx_char_length; // Length code of the pending buffer load
	logic tx_buf_empty_q; // Buffer has been taken by the shifter
	logic rts_ovr_q; // Override bit addressed
	logic rts_val_q; // Level written to the override bit

	// APB decode
	wire acc = PSEL & PENABLE & PREADY; // Completing edge
	wire wr = acc & PWRITE;
	wire wr_ctrl = wr & (PADDR == `SSX_OFS_CTRL);
	wire wr_cmd = wr & (PADDR == `SSX_OFS_CMD);
	wire wr_rts = wr & (PADDR == `SSX_OFS_RTS);
	wire wr_txd = wr & (PADDR == `SSX_OFS_TXDATA);
	wire wr_s1 = wr & (PADDR == `SSX_OFS_FIRST_SYNC_CHAR);
	wire wr_s2 = wr & (PADDR == `SSX_OFS_SECOND_SYNC_CHAR);
	wire mapped = (PADDR[1:0] == 2'h0) && (PADDR <= `SSX_OFS_STATUS);
	wire reset_cmd = wr_cmd & PWDATA[`SSX_K_RESET];
	wire clear_tx_cmd = reset_cmd | (wr_cmd & PWDATA[`SSX_K_CLRTX]);
	wire clear_rx_cmd = reset_cmd | (wr_cmd & PWDATA[`SSX_K_CLRRX]);
	wire clr_flags = wr_cmd & PWDATA[`SSX_K_CLRFLG];

	// Control fields
	wire [2:0] mode = ctrl_q[`SSX_C_MODE];
	wire mode1 = (mode == `SSX_MODE1);
	wire par_en = ctrl_q[`SSX_C_PAREN] & ~mode1;
	wire par_odd = ctrl_q[`SSX_C_PARODD];
	wire div32_select = ctrl_q[`SSX_C_DIV32];
	wire tx_enable_bit = ctrl_q[`SSX_C_TXEN];

	// Transmitter state
	ssx_tx_state_t tx_state_q;
	logic [8:0] tx_shift_reg;
	logic [3:0] tx_bit_counter; // Bits still to go after the current one
	logic tx_parity_acc;
	logic tx_par_pend_q; // Parity bit still owed for this character
	logic [2:0] tx_ones_counter;
	logic [4:0] tx_div_q; // Divide-by-32 pacing count
	logic cts_prev_q;
	logic [15:0] tx_check_reg;
	logic serial_out_q;
	logic rts_n_q;
	logic loop_synced_q; // Mode 1 loop slave has seen a flag

	// Strobe pacing: plain falls unless divided with clear-to-send up
	wire div_on = div32_select & cts_act;
	wire tx_shift_strobe = tx_fall & (~div_on | (tx_div_q == 5'h00));
	wire auto_send_request = (tx_state_q != TX_IDLE);
	wire at_boundary = (tx_bit_counter == 4'h0) & ~tx_par_pend_q;
	wire tx_shift_low_bit = tx_shift_reg[0];
	wire [8:0] sync_src = (mode == `SSX_MODE3) ? first_sync_char : second_sync_char;
	wire loop_through = mode1 & (ctrl_q[`SSX_C_CFG] == `SSX_CFG_LSLAVE) & ~loop_synced_q;

	// Divider: armed when clear-to-send rises while the clock is high
	always_ff @(posedge MCLK) begin
		cts_prev_q <= cts_act;
		if (SYS_RST) begin
			tx_div_q <= `SSX_DIV_FIRST;
		end else if (cts_act & ~cts_prev_q & tx_clk_s) begin
			tx_div_q <= `SSX_DIV_FIRST; // First strobe on second fall
		end else if (tx_fall & div_on) begin
			tx_div_q <= (tx_div_q == 5'h00) ? `SSX_DIV_RELOAD : tx_div_q - 5'h01;
		end
	end

	// Request pin retimed to the transmit clock fall; override bits taken at the write
	always_ff @(posedge MCLK) begin
		if (SYS_RST | clear_tx_cmd) begin
			rts_ovr_q <= 1'b0;
			rts_val_q <= 1'b0;
			rts_n_q <= 1'b1;
		end else begin
			if (wr_rts) begin
				rts_ovr_q <= 1'b1;
				rts_val_q <= PWDATA[0];
			end
			if (tx_fall) begin
				rts_n_q <= ~(rts_ovr_q ? rts_val_q : auto_send_request);
			end
		end
	end

	// Buffer load and empty flag; the shifter taking it wins over a late write
	wire take_buf = (tx_state_q == TX_RUN) & tx_shift_strobe & at_boundary & ~tx_buf_empty_q;
	always_ff @(posedge MCLK) begin
		if (SYS_RST | clear_tx_cmd) begin
			tx_buf_empty_q <= 1'b1;
		end else if (take_buf) begin
			tx_buf_empty_q <= 1'b1;
		end else if (wr_txd) begin
			tx_buf_empty_q <= 1'b0;
		end
		if (SYS_RST) begin
			tx_data_buffer <= 9'h000;
			tx_char_length <= 3'h0;
		end else if (wr_txd) begin
			tx_data_buffer <= PWDATA[8:0];
			tx_char_length <= PWDATA[`SSX_T_LEN]; // Own length per load
		end
	end

	// Transmit sequencer
	always_ff @(posedge MCLK) begin
		if (SYS_RST | clear_tx_cmd) begin
			tx_state_q <= TX_IDLE;
			tx_shift_reg <= 9'h1FF;
			tx_bit_counter <= 4'h0;
			tx_parity_acc <= 1'b0;
			tx_par_pend_q <= 1'b0;
			tx_ones_counter <= 3'h0;
			tx_check_reg <= 16'h0000;
			serial_out_q <= 1'b1;
		end else begin
			unique case (tx_state_q)
				TX_IDLE: begin
					if (tx_enable_bit) begin
						tx_state_q <= TX_WAIT;
					end
				end
				TX_WAIT: begin
					if (!tx_enable_bit) begin
						tx_state_q <= TX_IDLE;
					end else if (cts_act) begin
						tx_state_q <= TX_RUN;
					end
				end
				TX_RUN: begin
					if (tx_shift_strobe) begin
						if (!at_boundary && tx_bit_counter != 4'h0) begin
							// Next data bit of the character
							serial_out_q <= tx_shift_low_bit;
							tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
							tx_bit_counter <= tx_bit_counter - 4'h1;
							tx_parity_acc <= tx_parity_acc ^ tx_shift_low_bit;
							tx_check_reg <= ssx_crc(tx_check_reg, tx_shift_low_bit);
							if (mode1) begin
								tx_ones_counter <= tx_shift_low_bit ?
									((tx_ones_counter == 3'h7) ? 3'h7 : tx_ones_counter + 3'h1) :
									3'h0;
							end
						end else if (tx_par_pend_q) begin
							serial_out_q <= tx_parity_acc ^ par_odd;
							tx_par_pend_q <= 1'b0;
						end else if (!tx_buf_empty_q) begin
							// Buffer character, first bit goes out now
							serial_out_q <= tx_data_buffer[0];
							tx_shift_reg <= {1'b1, tx_data_buffer[8:1]};
							tx_bit_counter <= ssx_len(tx_char_length) - 4'h1;
							tx_parity_acc <= tx_data_buffer[0];
							tx_par_pend_q <= par_en;
							tx_check_reg <= ssx_crc(tx_check_reg, tx_data_buffer[0]);
						end else if (!tx_enable_bit) begin
							serial_out_q <= 1'b1; // Last character done
							tx_state_q <= TX_IDLE;
						end else begin
							// Fill with a sync character, never with parity
							serial_out_q <= sync_src[0];
							tx_shift_reg <= {1'b1, sync_src[8:1]};
							tx_bit_counter <= ssx_len(ctrl_q[`SSX_C_SYNCLEN]) - 4'h1;
							tx_par_pend_q <= 1'b0;
							tx_ones_counter <= 3'h0;
						end
					end
				end
			endcase
		end
	end

	// Serial output; loop slave passes the line through until synchronised
	logic serial_pin_q;
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			serial_pin_q <= 1'b1;
		end else begin
			serial_pin_q <= loop_through ? serial_in : serial_out_q;
		end
	end

	// Receiver state
	logic [9:0] rx_shift_reg;
	logic [8:0] rx_data_buffer;
	logic [8:0] rx_holding_reg;
	logic [8:0] rx_char_q; // Character waiting for its parity bit
	logic [2:0] rx_bit_count; // Length in force for the character in assembly
	logic rx_par_q;
	logic rx_par_phase_q;
	logic rx_buffer_loaded;
	logic rx_overrun_flag;
	logic rx_parity_error;
	logic [7:0] rx_mask_q; // Mode 1 flag hunter
	logic rx_synced_q;
	logic rx_one_sync_q; // Mode 3 has seen one sync so far
	logic rx_flag_seen_q;
	logic [4:0] rx_div_q;
	logic [15:0] rx_check_reg;

	// Sample strobe: each rise, or every 32nd starting at the 16th
	wire rx_sample_strobe = rx_rise & (~div32_select | (rx_div_q == 5'h00));
	always_ff @(posedge MCLK) begin
		if (SYS_RST | clear_rx_cmd) begin
			rx_div_q <= `SSX_RX_FIRST;
		end else if (rx_rise & div32_select) begin
			rx_div_q <= (rx_div_q == 5'h00) ? `SSX_DIV_RELOAD : rx_div_q - 5'h01;
		end
	end

	// Assembly arithmetic
	wire [3:0] rx_len = ssx_len(rx_bit_count);
	wire [9:0] rx_next = {serial_in, rx_shift_reg[9:1]};
	wire rx_done = rx_sample_strobe & ~rx_par_phase_q & ~rx_shift_reg[0];
	wire [9:0] rx_just = rx_next >> (4'hA - rx_len);
	wire [8:0] rx_word = rx_just[8:0];
	wire [8:0] len_mask = 9'h1FF >> (4'h9 - rx_len);
	wire sync_match = ((rx_word ^ first_sync_char) & len_mask) == 9'h000;
	wire [7:0] mask_next = {serial_in, rx_mask_q[7:1]};
	wire flag_hit = mode1 & rx_sample_strobe & (mask_next == `SSX_FLAG_PAT);
	wire hunting = ~rx_synced_q & (mode == `SSX_MODE2 || mode == `SSX_MODE3 || mode1);
	wire par_bad = serial_in ^ rx_par_q ^ par_odd;
	wire xfer_direct = rx_done & ~par_en & ~hunting;
	wire xfer_par = rx_sample_strobe & rx_par_phase_q;
	wire xfer = xfer_direct | xfer_par;
	wire [8:0] xfer_word = rx_par_phase_q ? rx_char_q : rx_word;

	// Shifter, parity, hunt and transfer
	always_ff @(posedge MCLK) begin
		if (SYS_RST | clear_rx_cmd) begin
			rx_mask_q <= 8'hFF;
			rx_shift_reg <= ssx_rx_init(ssx_len(ctrl_q[`SSX_C_RXLEN]));
			rx_bit_count <= ctrl_q[`SSX_C_RXLEN];
			rx_par_q <= 1'b0;
			rx_par_phase_q <= 1'b0;
			rx_synced_q <= 1'b0;
			rx_one_sync_q <= 1'b0;
			rx_char_q <= 9'h000;
			rx_check_reg <= 16'h0000;
		end else begin
			if (rx_sample_strobe) begin
				rx_mask_q <= mask_next;
				if (!rx_par_phase_q) begin
					rx_check_reg <= ssx_crc(rx_check_reg, serial_in);
				end
			end
			if (flag_hit) begin
				rx_synced_q <= 1'b1; // Frame opens, restart assembly
				rx_shift_reg <= ssx_rx_init(rx_len);
				rx_par_q <= 1'b0;
			end else if (rx_done) begin
				rx_shift_reg <= ssx_rx_init(ssx_len(ctrl_q[`SSX_C_RXLEN]));
				rx_par_q <= 1'b0;
				if (hunting) begin
					// Sync hunt in modes 2 and 3; mode 3 needs two in a row
					if (!mode1 && sync_match && (mode == `SSX_MODE2 || rx_one_sync_q)) begin
						rx_synced_q <= 1'b1;
					end
					rx_one_sync_q <= sync_match & ~mode1;
				end else if (par_en) begin
					rx_par_phase_q <= 1'b1;
					rx_char_q <= rx_word;
					rx_par_q <= rx_par_q ^ serial_in;
				end
			end else if (rx_sample_strobe && rx_par_phase_q) begin
				rx_par_phase_q <= 1'b0;
				// Checker starts from zero again, else parity leaks into the next character
				rx_par_q <= 1'b0;
			end else if (rx_sample_strobe) begin
				rx_shift_reg <= rx_next;
				rx_par_q <= rx_par_q ^ (serial_in & ~mode1);
			end
			if (xfer) begin
				rx_bit_count <= ctrl_q[`SSX_C_RXLEN];
			end
		end
	end

	// Receive buffer, holding copy and flags; set wins over clear
	always_ff @(posedge MCLK) begin
		if (SYS_RST | clear_rx_cmd) begin
			rx_buffer_loaded <= 1'b0;
			rx_overrun_flag <= 1'b0;
			rx_parity_error <= 1'b0;
			rx_flag_seen_q <= 1'b0;
			rx_data_buffer <= 9'h000;
			rx_holding_reg <= 9'h000;
		end else begin
			if (xfer) begin
				rx_holding_reg <= rx_data_buffer;
				rx_data_buffer <= xfer_word;
				rx_buffer_loaded <= 1'b1;
				rx_overrun_flag <= rx_buffer_loaded | (rx_overrun_flag & ~clr_flags);
				rx_parity_error <= xfer_par & par_bad;
			end else if (clr_flags) begin
				rx_buffer_loaded <= 1'b0;
				rx_overrun_flag <= 1'b0;
			end
			if (flag_hit) begin
				rx_flag_seen_q <= 1'b1;
			end else if (clr_flags) begin
				rx_flag_seen_q <= 1'b0;
			end
		end
	end

	// Loop slave leaves pass-through once a flag has been seen
	always_ff @(posedge MCLK) begin
		if (SYS_RST | clear_tx_cmd | clear_rx_cmd) begin
			loop_synced_q <= 1'b0;
		end else if (flag_hit) begin
			loop_synced_q <= 1'b1;
		end
	end

	// Interrupt sources and status word
	wire rx_int = rx_buffer_loaded & ctrl_q[`SSX_C_RXIEN];
	wire tx_int = tx_buf_empty_q & tx_enable_bit & ctrl_q[`SSX_C_TXIEN];
	wire int_any = rx_int | tx_int;
	wire any_flag = |ctrl_q[`SSX_C_HOLDRD:`SSX_C_LDRXCHK];
	wire err9 = mode1 ? rx_flag_seen_q : (rx_overrun_flag | rx_parity_error);
	wire [15:0] low_norm = {serial_in, 3'h0, rx_overrun_flag, rx_parity_error & ~mode1, err9,
		rx_data_buffer};
	// Low half switches with the load flags, first one set wins
	wire [15:0] low_sel = ctrl_q[`SSX_C_LDRXCHK] ? rx_check_reg :
		(ctrl_q[`SSX_C_LDTXCHK] | ctrl_q[`SSX_C_LDTXBUF]) ? tx_check_reg :
		ctrl_q[`SSX_C_HOLDRD] ? {7'h00, rx_holding_reg} : low_norm;
	wire [31:0] status = {int_any, any_flag, 1'b0, cts_act, dsr_act, auto_send_request, 3'h0,
		tx_buf_empty_q, rx_buffer_loaded, 3'h0, tx_int, rx_int, low_sel};
	wire [31:0] rd_mux = (PADDR == `SSX_OFS_CTRL) ? ctrl_q :
		(PADDR == `SSX_OFS_RTS) ? {30'h0, rts_val_q, rts_ovr_q} :
		(PADDR == `SSX_OFS_TXDATA) ? {31'h0, tx_buf_empty_q} :
		(PADDR == `SSX_OFS_FIRST_SYNC_CHAR) ? {23'h0, first_sync_char} :
		(PADDR == `SSX_OFS_SECOND_SYNC_CHAR) ? {23'h0, second_sync_char} :
		(PADDR == `SSX_OFS_STATUS) ? status : 32'h0000_0000;

	// APB slave: one wait state, registered answer
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end else begin
			PREADY <= PSEL & PENABLE & ~PREADY;
			PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
			PRDATA <= (PSEL & PENABLE & ~PREADY & ~PWRITE) ? rd_mux : 32'h0000_0000;
		end
	end

	// Writable registers
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			ctrl_q <= `SSX_CTRL_RST;
			first_sync_char <= 9'h000;
			second_sync_char <= 9'h000;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= PWDATA & `SSX_CTRL_WMASK;
			end
			if (wr_s1) begin
				first_sync_char <= PWDATA[8:0];
			end
			if (wr_s2) begin
				second_sync_char <= PWDATA[8:0];
			end
		end
	end

	// Pin outputs, interrupt pin active low
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			INT_N <= 1'b1;
		end else begin
			INT_N <= ~int_any;
		end
	end
	assign SERIAL_OUT = serial_pin_q;
	assign RTS_N = rts_n_q;
endmodule : ssx_core

// *** inc/ssx_defs.svh ***
// Register offsets, field positions, reset values and timing counts of the serial core
`ifndef SSX_DEFS_SVH
`define SSX_DEFS_SVH
`define SSX_OFS_CTRL 8'h00
`define SSX_OFS_CMD 8'h04
`define SSX_OFS_RTS 8'h08
`define SSX_OFS_TXDATA 8'h0C
`define SSX_OFS_FIRST_SYNC_CHAR 8'h10
`define SSX_OFS_SECOND_SYNC_CHAR 8'h14
`define SSX_OFS_STATUS 8'h18
`define SSX_CTRL_RST 32'h0000_0000
`define SSX_CTRL_WMASK 32'h0F0D_7FFF
`define SSX_C_RXLEN 2:0
`define SSX_C_CFG 5:4
`define SSX_C_MODE 8:6
`define SSX_C_PAREN 9
`define SSX_C_PARODD 10
`define SSX_C_DIV32 11
`define SSX_C_SYNCLEN 14:12
`define SSX_C_TXEN 16
`define SSX_C_RXIEN 18
`define SSX_C_TXIEN 19
`define SSX_C_LDRXCHK 24
`define SSX_C_LDTXCHK 25
`define SSX_C_LDTXBUF 26
`define SSX_C_HOLDRD 27
`define SSX_K_RESET 0
`define SSX_K_CLRTX 1
`define SSX_K_CLRRX 2
`define SSX_K_CLRFLG 18
`define SSX_T_LEN 14:12
`define SSX_MODE0 3'h0
`define SSX_MODE1 3'h1
`define SSX_MODE2 3'h2
`define SSX_MODE3 3'h3
`define SSX_CFG_LSLAVE 2'h2
`define SSX_DIV_RELOAD 5'h1F
`define SSX_DIV_FIRST 5'h01
`define SSX_RX_FIRST 5'h0F
`define SSX_FLAG_PAT 8'h7E
`define SSX_CRC_POLY 16'h1021
`endif

// *** inc/ssx_pkg.sv ***
// Types shared by the serial core
package ssx_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_RUN} ssx_tx_state_t;
endpackage : ssx_pkg

// *** verif/ssx_core_assertions.sv ***
// Port-level assertions for the serial core, bound to its top module
`timescale 1ns/100ps
`include "ssx_defs.svh"
module ssx_core_chk (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic TX_CLK_N,
	input wire logic SERIAL_OUT,
	input wire logic RTS_N,
	input wire logic INT_N
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	logic [3:0] since_fall_q; // Edges since the transmit clock was last seen low after high
	logic [31:0] ctrl_q; // Expected control contents after masking
	wire unmapped = (PADDR[1:0] != 2'h0) || (PADDR > `SSX_OFS_STATUS); // Refused addresses
	wire done = PSEL && PENABLE && PREADY; // Completing edge of a transfer
	// Soft reset or clear-transmit releases the request pin at once, with no clock fall
	wire tx_clear = done && PWRITE && PADDR == `SSX_OFS_CMD
		&& (PWDATA[`SSX_K_RESET] || PWDATA[`SSX_K_CLRTX]);
	// Saturating count; the request pin may only move shortly after a clock fall
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			since_fall_q <= 4'hF;
		end else if ($fell(TX_CLK_N)) begin
			since_fall_q <= 4'h0;
		end else if (since_fall_q != 4'hF) begin
			since_fall_q <= since_fall_q + 4'h1;
		end
	end
	// Shadow of control, taken only at a completing write
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			ctrl_q <= `SSX_CTRL_RST;
		end else if (done && PWRITE && PADDR == `SSX_OFS_CTRL) begin
			ctrl_q <= PWDATA & `SSX_CTRL_WMASK;
		end
	end
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_answer;
		!PREADY ##1 PREADY;
	endsequence
	property p_answer_wait;
		s_setup |=> s_answer;
	endproperty
	a_answer_wait: assert property (p_answer_wait)
		else $error("answer not after exactly one wait state");
	property p_ready_pulse;
		PREADY |=> !PREADY;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready longer than one cycle");
	property p_ready_in_access;
		PREADY |-> PSEL && PENABLE;
	endproperty
	a_ready_in_access: assert property (p_ready_in_access)
		else $error("ready outside an access phase");
	property p_err_decode;
		PREADY |-> PSLVERR == unmapped;
	endproperty
	a_err_decode: assert property (p_err_decode)
		else $error("error response does not match address decode");
	property p_rdata_idle;
		!PREADY |-> PRDATA == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside answer");
	property p_reads_zero;
		done && !PWRITE && (unmapped || PADDR == `SSX_OFS_CMD) |-> PRDATA == 32'h0;
	endproperty
	a_reads_zero: assert property (p_reads_zero)
		else $error("command or unmapped read not zero");
	property p_ctrl_readback;
		done && !PWRITE && PADDR == `SSX_OFS_CTRL |-> PRDATA == ctrl_q;
	endproperty
	a_ctrl_readback: assert property (p_ctrl_readback)
		else $error("control read differs from last write");
	property p_reset_idle;
		$fell(SYS_RST) |-> SERIAL_OUT && RTS_N && INT_N && !PREADY;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("outputs not idle after reset");
	property p_rts_on_fall;
		$changed(RTS_N) |-> since_fall_q <= 4'h8 || $past(tx_clear);
	endproperty
	a_rts_on_fall: assert property (p_rts_on_fall)
		else $error("request pin moved without a transmit clock fall");
endmodule : ssx_core_chk
bind ssx_core ssx_core_chk ssx_core_chk_inst (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .TX_CLK_N(TX_CLK_N), .SERIAL_OUT(SERIAL_OUT),
	.RTS_N(RTS_N), .INT_N(INT_N));

// *** verif/ssx_modem_model.sv ***
// Modem-side model: line clocks, receive data and capture of transmit data
`timescale 1ns/100ps
module ssx_modem_model (
	output logic tx_clk_n,
	output logic rx_clk,
	output logic serial_in,
	input wire logic serial_out
);
	logic [31:0] got; // Captured transmit bits, newest in bit 31
	// Clocks stand still between frames
	initial begin
		tx_clk_n = 1'b1;
		rx_clk = 1'b0;
		serial_in = 1'b1;
		got = 32'h0;
	end
	// Each bit set up half a period before its rising edge, low bit first
	task automatic send_bits(input logic [15:0] bits, input int n, input int hp);
		for (int i = 0; i < n; i++) begin
			serial_in = bits[i];
			#(hp) rx_clk = 1'b1;
			#(hp) rx_clk = 1'b0;
		end
		// Line not held after the frame, so it shows a changed level
		serial_in = ~serial_in;
	endtask : send_bits
	// Falls shift the transmitter; the line is taken before the next fall
	task automatic take_bits(input int n, input int hp);
		for (int i = 0; i < n; i++) begin
			#(hp) tx_clk_n = 1'b0;
			#(hp) tx_clk_n = 1'b1;
			got = {serial_out, got[31:1]};
		end
	endtask : take_bits
endmodule : ssx_modem_model

// *** verif/ssx_core_tb.sv ***
// Self-checking testbench: register traffic and both serial directions
`timescale 1ns/100ps
`include "ssx_defs.svh"
module ssx_core_tb;
	logic mclk;
	logic sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic cts_n = 1'b1, dsr_n = 1'b1, pready, pslverr, serial_out, rts_n, int_n;
	logic [7:0] paddr = 8'h00, t, u;
	logic [31:0] pwdata = 32'h0, prdata, v;
	wire tx_clk_n, rx_clk, serial_in;
	logic [32:0] exp_q[$], msk_q[$], mon_e, mon_m; // Expected answers, oldest first
	int n_errors = 0, n_compared = 0, cyc = 0, hit;
	ssx_core ssx_core_inst (.MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TX_CLK_N(tx_clk_n), .RX_CLK(rx_clk), .CTS_N(cts_n), .DSR_N(dsr_n),
		.SERIAL_IN(serial_in), .SERIAL_OUT(serial_out), .RTS_N(rts_n), .INT_N(int_n));
	ssx_modem_model ssx_modem_model_inst (.tx_clk_n(tx_clk_n), .rx_clk(rx_clk),
		.serial_in(serial_in), .serial_out(serial_out));
	// 40 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic conclude;
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	// One transfer; the note goes out first, request held until ready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0, {1'b1, 32'h0});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
	endtask : rd
	task automatic rx_char(input logic [15:0] b, input int n, input int hp);
		ssx_modem_model_inst.send_bits(b, n, hp);
		repeat (6) @(posedge mclk);
	endtask : rx_char
	task automatic tx_falls(input int n);
		ssx_modem_model_inst.take_bits(n, 210);
	endtask : tx_falls
	// Monitor: each completed transfer takes the oldest note, compared under its mask
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'b1) begin
			mon_e = exp_q.pop_front();
			mon_m = msk_q.pop_front();
			if (mon_m !== 33'h0) begin
				check({pslverr, prdata} & mon_m, mon_e & mon_m);
			end
		end
	end
	// Watchdog; the run needs under two thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			$display("MISMATCH at %0t: run did not finish", $time);
			conclude();
		end
	end
	initial begin
		v = $urandom(32'h66B22253);
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		check({serial_out, rts_n, int_n}, 33'h7);
		// Register map: reset value, write-only, unmapped and misaligned places
		rd(`SSX_OFS_CTRL, `SSX_CTRL_RST, 32'hFFFFFFFF);
		rd(`SSX_OFS_CMD, 32'h0, 32'hFFFFFFFF);
		apb(1'b0, 8'h1C, 32'h0, {1'b1, 32'h0}, {1'b1, 32'hFFFFFFFF});
		apb(1'b1, 8'h02, 32'hFFFFFFFF, {1'b1, 32'h0}, {1'b1, 32'h0});
		rd(`SSX_OFS_CTRL, 32'h0, 32'hFFFFFFFF);
		v = $urandom() & `SSX_CTRL_WMASK;
		wr(`SSX_OFS_CTRL, v);
		rd(`SSX_OFS_CTRL, v, 32'hFFFFFFFF);
		// Receive eight-bit characters with the receive interrupt enabled
		wr(`SSX_OFS_CTRL, 32'h0004_0006);
		wr(`SSX_OFS_CMD, 32'h4);
		t = $urandom();
		rx_char({8'h0, t}, 8, 190);
		rd(`SSX_OFS_STATUS, 32'h0020_0000 | t, 32'h0020_0FFF);
		check(int_n, 1'b0);
		u = $urandom();
		rx_char({8'h0, u}, 8, 300);
		rd(`SSX_OFS_STATUS, 32'h0020_0A00 | u, 32'h0020_0FFF);
		wr(`SSX_OFS_CMD, 32'h0004_0000);
		rd(`SSX_OFS_STATUS, 32'h0, 32'h0020_0800);
		check(int_n, 1'b1);
		// Five-bit characters, even parity: a wrong parity bit, then a right one
		wr(`SSX_OFS_CTRL, 32'h0000_0203);
		wr(`SSX_OFS_CMD, 32'h4);
		t = $urandom() & 8'h1F;
		rx_char({10'h0, ~^t[4:0], t[4:0]}, 6, 190);
		rd(`SSX_OFS_STATUS, 32'h0020_0600 | t, 32'h0020_0FFF);
		u = $urandom() & 8'h1F;
		rx_char({10'h0, ^u[4:0], u[4:0]}, 6, 190);
		rd(`SSX_OFS_STATUS, 32'h0 | u, 32'h0000_05FF);
		rd(`SSX_OFS_STATUS, {16'h0, serial_in, 15'h0}, 32'h0000_8000);
		wr(`SSX_OFS_CMD, 32'h4);
		rd(`SSX_OFS_STATUS, 32'h0, 32'h0020_0C00);
		// Mode 2 drops characters until one matches the first sync register
		wr(`SSX_OFS_FIRST_SYNC_CHAR, 32'h0000_0016);
		wr(`SSX_OFS_CTRL, 32'h0000_0086);
		wr(`SSX_OFS_CMD, 32'h4);
		rx_char(16'h0069, 8, 190);
		rd(`SSX_OFS_STATUS, 32'h0, 32'h0020_0000);
		rx_char(16'h0016, 8, 190);
		rx_char({8'h0, t}, 8, 190);
		rd(`SSX_OFS_STATUS, 32'h0020_0000 | t, 32'h0020_01FF);
		wr(`SSX_OFS_CTRL, 32'h0800_0203);
		rd(`SSX_OFS_STATUS, 32'h4000_0000, 32'h4000_0000);
		// Transmit an eight-bit then a five-bit load, even parity
		wr(`SSX_OFS_CTRL, 32'h0000_0200);
		wr(`SSX_OFS_CMD, 32'h2);
		t = $urandom();
		u = $urandom() & 8'h1F;
		wr(`SSX_OFS_TXDATA, 32'h0000_6000 | t);
		rd(`SSX_OFS_TXDATA, 32'h0, 32'h1);
		wr(`SSX_OFS_CTRL, 32'h0001_0200);
		check(rts_n, 1'b1);
		cts_n <= 1'b0;
		dsr_n <= 1'b0;
		tx_falls(3);
		wr(`SSX_OFS_TXDATA, 32'h0000_3000 | u);
		tx_falls(21);
		v = ssx_modem_model_inst.got;
		hit = 0;
		for (int k = 0; k < 4; k++) begin
			if (v[8 + k +: 8] === t && v[16 + k] === ^t && v[17 + k +: 5] === u[4:0]
				&& v[22 + k] === ^u[4:0]) begin
				hit = 1;
			end
		end
		check(hit, 33'h1);
		rd(`SSX_OFS_STATUS, 32'h1C40_0000, 32'h1C40_0000);
		check(rts_n, 1'b0);
		// Request override both ways, then the clear-transmit command drops it
		wr(`SSX_OFS_RTS, 32'h0);
		tx_falls(2);
		check(rts_n, 1'b1);
		wr(`SSX_OFS_RTS, 32'h1);
		wr(`SSX_OFS_CTRL, 32'h0000_0200);
		tx_falls(2);
		check(rts_n, 1'b0);
		rd(`SSX_OFS_RTS, 32'h3, 32'h3);
		wr(`SSX_OFS_CMD, 32'h2);
		tx_falls(2);
		check({serial_out, rts_n}, 33'h3);
		rd(`SSX_OFS_RTS, 32'h0, 32'h1);
		conclude();
	end
endmodule : ssx_core_tb
